// ---- hdl/dword_ops_cfg.svh ----
// constants for the doubleword store, trap and buffer-flush decoder
// assumes instruction bit 0 is the msb (bit 31 of the word)
`ifndef DWORD_OPS_CFG_SVH
`define DWORD_OPS_CFG_SVH
// primary and extended opcodes
`define OPC_X        6'h1f
`define OPC_STDU     6'h3e
`define OPC_TDI      6'h02
`define SUB_STDU     2'h1
`define XO_STDCX     10'h0d6
`define XO_STDX      10'h095
`define XO_STDUX     10'h0b5
`define XO_STFIWX    10'h3d7
`define XO_TRAP_RR   10'h044
`define XO_TLBIA     10'h172
`define XO_TLBIEX    10'h152
`define XO_TLBSYNC   10'h236
// trap mask bit positions inside the 5-bit field
`define TO_LT        4
`define TO_GT        3
`define TO_EQ        2
`define TO_LTU       1
`define TO_GTU       0
// access sizes in bytes and alignment
`define BYTES_DW     4'h8
`define BYTES_W      4'h4
`define DW_ALIGN     3'h7
// register map, byte addresses
`define REG_CTRL     32'h0000_0000
`define REG_STATUS   32'h0000_0004
`define REG_ILLEGAL  32'h0000_0008
`define REG_TRAPS    32'h0000_000c
`define REG_STORES   32'h0000_0010
`define CTRL_WIDE    0
`define CTRL_RESET   1'h0
`define ST_SYNC      0
`define ST_WIDE      1
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// ---- hdl/dword_ops_pkg.sv ----
// types for the doubleword store, trap and buffer-flush decoder
// assumes nothing beyond the cfg header
package dword_ops_pkg;
	typedef enum logic [3:0] {
		op_none, op_stdcx, op_stdu, op_stdux, op_stdx, op_stfiwx,
		op_trap_rr, op_tdi, op_tlbia, op_tlbiex, op_tlbsync
	} op_t;
	typedef enum logic {sync_idle, sync_wait} sync_state_t;
endpackage

// ---- hdl/dword_ops.sv ----
// decoder and executor for doubleword stores, traps and buffer flushes
// assumes operands are read by the core on aclk; sync_ack comes from afar
`timescale 1ns/1ps
`include "dword_ops_cfg.svh"
`default_nettype none

module dword_ops (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic        instr_valid,
	input  wire logic [31:0] instr,
	input  wire logic [63:0] base_gpr,
	input  wire logic [63:0] index_gpr,
	input  wire logic [63:0] source_gpr,
	input  wire logic [63:0] source_fpr,
	input  wire logic        reservation,
	input  wire logic        summary_overflow_flag,
	input  wire logic        supervisor,
	input  wire logic        sync_ack,
	output logic             instr_ready,
	output logic             done,
	output logic             store_valid,
	output logic [63:0]      store_addr,
	output logic [63:0]      store_data,
	output logic [3:0]       store_bytes,
	output logic             base_wb_valid,
	output logic [63:0]      base_wb_data,
	output logic             cond_field_valid,
	output logic [3:0]       first_condition_field,
	output logic             reserve_clear,
	output logic             trap_exc,
	output logic             illegal_exc,
	output logic             align_exc,
	output logic             priv_exc,
	output logic             sync_req,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ****************************************
	// helpers
	// ****************************************

	// trap mask evaluation shared by both trap forms
	function automatic logic trap_hit(input logic [63:0] a, input logic [63:0] b,
			input logic [4:0] to);
		logic lt_s;
		logic gt_s;
		lt_s = $signed(a) < $signed(b);
		gt_s = $signed(a) > $signed(b);
		trap_hit = (to[`TO_LT] & lt_s) | (to[`TO_GT] & gt_s) | (to[`TO_EQ] & (a == b)) |
			(to[`TO_LTU] & (a < b)) | (to[`TO_GTU] & (a > b));
	endfunction

	// opcode decode of this group only
	function automatic dword_ops_pkg::op_t decode(input logic [31:0] w);
		decode = dword_ops_pkg::op_none;
		if (w[31:26] == `OPC_STDU && w[1:0] == `SUB_STDU) begin
			decode = dword_ops_pkg::op_stdu;
		end else if (w[31:26] == `OPC_TDI) begin
			decode = dword_ops_pkg::op_tdi;
		end else if (w[31:26] == `OPC_X) begin
			case (w[10:1])
				`XO_STDCX:   decode = w[0] ? dword_ops_pkg::op_stdcx : dword_ops_pkg::op_none;
				`XO_STDX:    decode = dword_ops_pkg::op_stdx;
				`XO_STDUX:   decode = dword_ops_pkg::op_stdux;
				`XO_STFIWX:  decode = dword_ops_pkg::op_stfiwx;
				`XO_TRAP_RR: decode = dword_ops_pkg::op_trap_rr;
				`XO_TLBIA:   decode = dword_ops_pkg::op_tlbia;
				`XO_TLBIEX:  decode = dword_ops_pkg::op_tlbiex;
				`XO_TLBSYNC: decode = dword_ops_pkg::op_tlbsync;
				default:     decode = dword_ops_pkg::op_none;
			endcase
		end
	endfunction

	// ****************************************
	// decode and address formation
	// ****************************************

	logic                      wide;
	logic                      sync_meta;
	logic                      sync_ack_s;
	logic                      ack_low_seen;
	logic                      sync_fin;
	dword_ops_pkg::sync_state_t sync_state;
	dword_ops_pkg::op_t        op;
	logic                      accept;
	logic                      is_dword;
	logic                      is_update;
	logic                      illegal;
	logic                      priv_bad;
	logic                      misalign;
	logic [63:0]               base_or_zero;
	logic [63:0]               ea_x;
	logic [63:0]               ea_d;
	logic [63:0]               imm_ext;
	logic [63:0]               fpr_addr;

	assign op = decode(instr);
	assign accept = ce & instr_valid & instr_ready;
	assign is_dword = op == dword_ops_pkg::op_stdcx || op == dword_ops_pkg::op_stdu ||
		op == dword_ops_pkg::op_stdux || op == dword_ops_pkg::op_stdx ||
		op == dword_ops_pkg::op_trap_rr || op == dword_ops_pkg::op_tdi;
	assign is_update = op == dword_ops_pkg::op_stdu || op == dword_ops_pkg::op_stdux;
	// flush ops trap to software emulation; update forms need a real base
	assign illegal = (is_dword & ~wide)
		| op == dword_ops_pkg::op_tlbia | op == dword_ops_pkg::op_tlbiex
		| (is_update & instr[20:16] == 5'h00);
	assign priv_bad = op == dword_ops_pkg::op_tlbsync & ~supervisor;
	assign base_or_zero = (instr[20:16] == 5'h00) ? 64'h0 : base_gpr;
	assign ea_x = base_or_zero + index_gpr;
	assign ea_d = base_gpr + {{48{instr[15]}}, instr[15:2], 2'h0};
	assign imm_ext = {{48{instr[15]}}, instr[15:0]};
	// narrow mode keeps only a 32-bit effective address
	assign fpr_addr = wide ? ea_x : {32'h0, ea_x[31:0]};
	assign misalign = (ea_x[2:0] & `DW_ALIGN) != 3'h0;
	// a sync finishes only on an ack that rose after its own request
	assign sync_fin = sync_state == dword_ops_pkg::sync_wait & sync_ack_s & ack_low_seen;

	// ****************************************
	// far acknowledge synchroniser
	// ****************************************

	// ack comes from other processors, so two flops before any use
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_meta <= 1'b0;
			sync_ack_s <= 1'b0;
		end else if (ce) begin
			sync_meta <= sync_ack;
			sync_ack_s <= sync_meta;
		end
	end

	// flush-sync stall; the last sync's ack, still in the synchroniser, must fall first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_state <= dword_ops_pkg::sync_idle;
			sync_req <= 1'b0;
			instr_ready <= 1'b1;
			ack_low_seen <= 1'b0;
		end else if (ce) begin
			case (sync_state)
				dword_ops_pkg::sync_idle: begin
					if (accept && op == dword_ops_pkg::op_tlbsync && !priv_bad) begin
						sync_state <= dword_ops_pkg::sync_wait;
						sync_req <= 1'b1;
						instr_ready <= 1'b0;
						ack_low_seen <= 1'b0;
					end
				end
				dword_ops_pkg::sync_wait: begin
					if (sync_fin) begin
						sync_state <= dword_ops_pkg::sync_idle;
						sync_req <= 1'b0;
						instr_ready <= 1'b1;
					end else if (!sync_ack_s) begin
						ack_low_seen <= 1'b1;
					end
				end
				default: sync_state <= dword_ops_pkg::sync_idle;
			endcase
		end
	end

	// ****************************************
	// execution
	// ****************************************

	// one-cycle result pulses; exceptions suppress every other effect except done
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done <= 1'b0;
			store_valid <= 1'b0;
			store_addr <= 64'h0;
			store_data <= 64'h0;
			store_bytes <= 4'h0;
			base_wb_valid <= 1'b0;
			base_wb_data <= 64'h0;
			cond_field_valid <= 1'b0;
			first_condition_field <= 4'h0;
			reserve_clear <= 1'b0;
			trap_exc <= 1'b0;
			illegal_exc <= 1'b0;
			align_exc <= 1'b0;
			priv_exc <= 1'b0;
		end else if (ce) begin
			done <= sync_fin;
			store_valid <= 1'b0;
			base_wb_valid <= 1'b0;
			cond_field_valid <= 1'b0;
			reserve_clear <= 1'b0;
			trap_exc <= 1'b0;
			illegal_exc <= 1'b0;
			align_exc <= 1'b0;
			priv_exc <= 1'b0;
			if (accept && op != dword_ops_pkg::op_none) begin
				done <= op != dword_ops_pkg::op_tlbsync || illegal || priv_bad;
				if (illegal) begin
					illegal_exc <= 1'b1;
				end else if (priv_bad) begin
					priv_exc <= 1'b1;
				end else begin
					case (op)
						dword_ops_pkg::op_stdcx: begin
							if (misalign) begin
								align_exc <= 1'b1;
							end else begin
								cond_field_valid <= 1'b1;
								first_condition_field <= {2'h0, reservation,
									summary_overflow_flag};
								store_valid <= reservation;
								reserve_clear <= reservation;
								store_addr <= ea_x;
								store_data <= source_gpr;
								store_bytes <= `BYTES_DW;
							end
						end
						dword_ops_pkg::op_stdu: begin
							store_valid <= 1'b1;
							store_addr <= ea_d;
							store_data <= source_gpr;
							store_bytes <= `BYTES_DW;
							base_wb_valid <= 1'b1;
							base_wb_data <= ea_d;
						end
						dword_ops_pkg::op_stdux: begin
							store_valid <= 1'b1;
							store_addr <= ea_x;
							store_data <= source_gpr;
							store_bytes <= `BYTES_DW;
							base_wb_valid <= 1'b1;
							base_wb_data <= ea_x;
						end
						dword_ops_pkg::op_stdx: begin
							store_valid <= 1'b1;
							store_addr <= ea_x;
							store_data <= source_gpr;
							store_bytes <= `BYTES_DW;
						end
						dword_ops_pkg::op_stfiwx: begin
							store_valid <= 1'b1;
							store_addr <= fpr_addr;
							store_data <= {32'h0, source_fpr[31:0]};
							store_bytes <= `BYTES_W;
						end
						dword_ops_pkg::op_trap_rr: begin
							trap_exc <= trap_hit(base_gpr, index_gpr, instr[25:21]);
						end
						dword_ops_pkg::op_tdi: begin
							trap_exc <= trap_hit(base_gpr, imm_ext, instr[25:21]);
						end
						default: begin
							// flush-sync completes from the stall machine
						end
					endcase
				end
			end
		end
	end

	// ****************************************
	// register slave
	// ****************************************

	logic [31:0] cnt_illegal;
	logic [31:0] cnt_traps;
	logic [31:0] cnt_stores;
	logic        aw_hs;
	logic        ar_hs;

	assign aw_hs = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
	assign ar_hs = s_axi_arvalid & s_axi_arready;

	// event counters let software see the block's activity
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_illegal <= 32'h0;
			cnt_traps <= 32'h0;
			cnt_stores <= 32'h0;
		end else if (ce) begin
			cnt_illegal <= cnt_illegal + {31'h0, illegal_exc};
			cnt_traps <= cnt_traps + {31'h0, trap_exc};
			cnt_stores <= cnt_stores + {31'h0, store_valid};
		end
	end

	// write channel: both address and data taken together, one at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			wide <= `CTRL_RESET;
		end else if (ce) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			if (aw_hs) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				if (s_axi_awaddr == `REG_CTRL) begin
					if (s_axi_wstrb[0]) begin
						wide <= s_axi_wdata[`CTRL_WIDE];
					end
				end else if (s_axi_awaddr == `REG_STATUS || s_axi_awaddr == `REG_ILLEGAL ||
						s_axi_awaddr == `REG_TRAPS || s_axi_awaddr == `REG_STORES) begin
					// read-only words ignore writes
					s_axi_bresp <= `RESP_OKAY;
				end else begin
					s_axi_bresp <= `RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end else if (!s_axi_bvalid && !s_axi_awready && s_axi_awvalid && s_axi_wvalid) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// read channel: ready pulse, then data one cycle later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `RESP_OKAY;
		end else if (ce) begin
			s_axi_arready <= 1'b0;
			if (ar_hs) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				s_axi_rdata <= 32'h0;
				if (s_axi_araddr == `REG_CTRL) begin
					s_axi_rdata[`CTRL_WIDE] <= wide;
				end else if (s_axi_araddr == `REG_STATUS) begin
					s_axi_rdata[`ST_SYNC] <= sync_state == dword_ops_pkg::sync_wait;
					s_axi_rdata[`ST_WIDE] <= wide;
				end else if (s_axi_araddr == `REG_ILLEGAL) begin
					s_axi_rdata <= cnt_illegal;
				end else if (s_axi_araddr == `REG_TRAPS) begin
					s_axi_rdata <= cnt_traps;
				end else if (s_axi_araddr == `REG_STORES) begin
					s_axi_rdata <= cnt_stores;
				end else begin
					s_axi_rresp <= `RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end else if (!s_axi_rvalid && !s_axi_arready && s_axi_arvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ****************************************
	// assertions
	// ****************************************

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic ok;
	assign ok = accept & ~illegal & ~priv_bad;

	a_stdcx_store: assert property (ok && op == dword_ops_pkg::op_stdcx && !misalign && reservation |=> store_valid && reserve_clear && store_bytes == `BYTES_DW) else $error("stdcx store missing");
	a_stdcx_nostore: assert property (ok && op == dword_ops_pkg::op_stdcx && !reservation |=> !store_valid && !reserve_clear) else $error("stdcx stored without reservation");
	a_cond_field: assert property (ok && op == dword_ops_pkg::op_stdcx && !misalign |=>
		cond_field_valid && first_condition_field ==
		{2'h0, $past(reservation), $past(summary_overflow_flag)})
		else $error("condition field wrong");
	a_stdcx_align: assert property (ok && op == dword_ops_pkg::op_stdcx && misalign |=>
		align_exc && !store_valid && !cond_field_valid)
		else $error("misaligned stdcx not trapped");
	a_narrow_illegal: assert property (accept && is_dword && !wide |=> illegal_exc &&
		!store_valid && !base_wb_valid && !cond_field_valid && !trap_exc)
		else $error("narrow dword op not illegal");
	a_stdu_update: assert property (ok && op == dword_ops_pkg::op_stdu |=> store_valid && base_wb_valid && base_wb_data == store_addr && store_addr == $past(ea_d)) else $error("stdu update wrong");
	a_update_form: assert property (accept && is_update && instr[20:16] == 5'h00 |=> illegal_exc && !base_wb_valid) else $error("invalid update form accepted");
	a_stdx_addr: assert property (ok && op == dword_ops_pkg::op_stdx |=> store_valid && !base_wb_valid && store_addr == $past(ea_x)) else $error("stdx address wrong");
	a_stfiwx_data: assert property (ok && op == dword_ops_pkg::op_stfiwx |=> store_bytes == `BYTES_W && store_data[31:0] == $past(source_fpr[31:0])) else $error("stfiwx data wrong");
	// back-to-back issue is legal, so only the cycle after acceptance is judged
	a_flush_illegal: assert property (accept && (op == dword_ops_pkg::op_tlbia ||
		op == dword_ops_pkg::op_tlbiex) |=> illegal_exc && done && !store_valid && !priv_exc)
		else $error("flush not illegal");
	a_sync_priv: assert property (accept && priv_bad |=> priv_exc && !sync_req) else $error("user flush-sync not refused");
	a_sync_stall: assert property (sync_state == dword_ops_pkg::sync_wait && !sync_ack_s |=> !instr_ready && sync_req && !done) else $error("flush-sync did not stall");

	c_stdcx_done: cover property (ok && op == dword_ops_pkg::op_stdcx && reservation ##1 store_valid);
	c_trap_taken: cover property (ok && op == dword_ops_pkg::op_trap_rr ##1 trap_exc);
	c_sync_done: cover property (sync_req ##[1:20] done);

endmodule

`default_nettype wire

// ---- verification/core_partner.sv ----
// far-side model: other processors answering a flush-sync
// assumes sync_req stays high until the acknowledge is seen
`timescale 1ns/1ps
`default_nettype none

module core_partner (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic sync_req,
	input  wire logic slow,
	output logic      sync_ack
);
	// ************************************************
	// acknowledge
	// ************************************************
	logic [4:0] wait_cnt;

	// ack level after a short or long delay; dropped with the request
	always_ff @(posedge aclk) begin
		if (!aresetn || !sync_req) begin
			wait_cnt <= 5'h00;
			sync_ack <= 1'b0;
		end else if (wait_cnt == (slow ? 5'h14 : 5'h01)) begin
			sync_ack <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt + 5'h01;
		end
	end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the doubleword store, trap and flush decoder
// assumes dword_ops and core_partner are compiled before it
`timescale 1ns/1ps
`include "dword_ops_cfg.svh"
`default_nettype none

module tb;
	logic        aclk, aresetn, instr_valid, instr_ready, done, reservation, supervisor, slow;
	logic        summary_overflow_flag, sync_ack, sync_req, store_valid, base_wb_valid;
	logic        cond_field_valid, reserve_clear, trap_exc, illegal_exc, align_exc, priv_exc, ce;
	logic [31:0] instr, s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd, op;
	logic [63:0] base_gpr, index_gpr, source_gpr, source_fpr, store_addr, store_data;
	logic [63:0] base_wb_data;
	logic [3:0]  store_bytes, first_condition_field, s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	int          failures, checks_done;
	localparam logic [63:0] src_val = 64'h1122_3344_5566_7788;

	dword_ops dut_u (.aclk, .aresetn, .ce, .instr_valid, .instr, .base_gpr, .index_gpr,
		.source_gpr, .source_fpr, .reservation, .summary_overflow_flag, .supervisor, .sync_ack,
		.instr_ready, .done, .store_valid, .store_addr, .store_data, .store_bytes,
		.base_wb_valid, .base_wb_data, .cond_field_valid, .first_condition_field, .reserve_clear,
		.trap_exc, .illegal_exc, .align_exc, .priv_exc, .sync_req, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	core_partner partner_u (.aclk, .aresetn, .sync_req, .slow, .sync_ack);

	// 4 ns period
	always #2 aclk = ~aclk;

	// ************************************************
	// helpers
	// ************************************************
	// x-form word; index field kept zero so reserved fields stay clean
	function automatic logic [31:0] xf(input logic [4:0] src_f, base_f, input logic [9:0] xo,
			input logic rc);
		return {`OPC_X, src_f, base_f, 5'h00, xo, rc};
	endfunction

	// compare and count
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// summary and end of run
	task automatic give_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// a wait ran out
	task automatic hang();
		failures++;
		give_verdict();
	endtask

	// one write; address and data offered together
	task automatic axi_write(input logic [31:0] a, d);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge aclk) n++; while (!(s_axi_awready && s_axi_wready) && n < 50);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge aclk) n++; while (!s_axi_bvalid && n < 100);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 100) hang();
	endtask

	// one read
	task automatic axi_read(input logic [31:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk) n++; while (!s_axi_arready && n < 50);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk) n++; while (!s_axi_rvalid && n < 100);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 100) hang();
	endtask

	// one instruction; result pulses land one edge after acceptance
	task automatic issue(input logic [31:0] ins, input logic [63:0] a, b, s,
			input logic r, input logic [8:0] exp);
		@(posedge aclk);
		instr <= ins;
		base_gpr <= a;
		index_gpr <= b;
		source_gpr <= s;
		source_fpr <= s;
		reservation <= r;
		instr_valid <= 1'b1;
		@(posedge aclk);
		instr_valid <= 1'b0;
		#1;
		chk({store_valid, base_wb_valid, cond_field_valid, reserve_clear, trap_exc, illegal_exc,
			align_exc, priv_exc, done}, {55'h0, exp});
	endtask

	// ************************************************
	// scenarios
	// ************************************************
	// reset values, unmapped place, read-only counter
	task automatic regs_check();
		axi_read(`REG_CTRL);
		chk(rd, 32'h0);
		axi_read(32'h0000_0040);
		chk(resp, `RESP_SLVERR);
		axi_write(32'h0000_0020, 32'h0000_0001);
		chk(resp, `RESP_SLVERR);
		axi_write(`REG_STORES, 32'h0000_0055);
		chk(resp, `RESP_OKAY);
		axi_read(`REG_STORES);
		chk(rd, 32'h0);
	endtask

	// every doubleword form is refused in 32-bit mode, nothing else moves
	task automatic narrow_mode();
		logic [31:0] ops [6];
		ops = '{xf(5'h01, 5'h03, `XO_STDCX, 1'b1), {`OPC_STDU, 10'h023, 14'h0002, `SUB_STDU},
			xf(5'h01, 5'h03, `XO_STDUX, 1'b0), xf(5'h01, 5'h03, `XO_STDX, 1'b0),
			xf(5'h1f, 5'h03, `XO_TRAP_RR, 1'b0), {`OPC_TDI, 10'h3e3, 16'h0000}};
		foreach (ops[i]) issue(ops[i], 64'h1000, 64'h8, src_val, 1'b1, 9'h009);
		axi_write(`REG_CTRL, 32'h0000_0001);
		axi_read(`REG_STATUS);
		chk(rd, 32'h2);
	endtask

	// conditional store with and without reservation, then misaligned
	task automatic cond_store();
		op = xf(5'h01, 5'h03, `XO_STDCX, 1'b1);
		summary_overflow_flag <= 1'b1;
		issue(op, 64'h1000, 64'h20, src_val, 1'b1, 9'h161);
		chk(store_addr, 64'h1020);
		chk(store_data, src_val);
		chk(store_bytes, `BYTES_DW);
		chk(first_condition_field, 4'h3);
		summary_overflow_flag <= 1'b0;
		issue(op, 64'h1000, 64'h20, src_val, 1'b0, 9'h041);
		chk(first_condition_field, 4'h0);
		issue(op, 64'h1000, 64'h4, src_val, 1'b1, 9'h005);
	endtask

	// update forms: negative displacement, indexed sum, base field zero
	task automatic update_stores();
		issue({`OPC_STDU, 10'h023, 14'h3ffe, `SUB_STDU}, 64'h2000, 0, src_val, 1'b0, 9'h181);
		chk(store_addr, 64'h1ff8);
		chk(base_wb_data, 64'h1ff8);
		issue({`OPC_STDU, 10'h020, 14'h3ffe, `SUB_STDU}, 64'h2000, 0, src_val, 1'b0, 9'h009);
		issue(xf(5'h01, 5'h05, `XO_STDUX, 1'b0), 64'h100, 64'h28, src_val, 1'b0, 9'h181);
		chk(store_addr, 64'h128);
		chk(base_wb_data, 64'h128);
		issue(xf(5'h01, 5'h00, `XO_STDUX, 1'b0), 64'h100, 64'h28, src_val, 1'b0, 9'h009);
	endtask

	// indexed store with zero base field, word store of the fpr low half
	task automatic indexed_stores();
		issue(xf(5'h01, 5'h00, `XO_STDX, 1'b0), 64'hdead, 64'h3000, src_val, 1'b0, 9'h101);
		chk(store_addr, 64'h3000);
		issue(xf(5'h01, 5'h02, `XO_STFIWX, 1'b0), 64'h10, 64'h4, src_val, 1'b0, 9'h101);
		chk(store_addr, 64'h14);
		chk(store_data, 64'h5566_7788);
		chk(store_bytes, `BYTES_W);
	endtask

	// clock enable low freezes the block; the held instruction runs once it rises
	task automatic freeze();
		@(posedge aclk);
		ce <= 1'b0;
		instr <= xf(5'h01, 5'h00, `XO_STDX, 1'b0);
		index_gpr <= 64'h40;
		instr_valid <= 1'b1;
		repeat (3) @(posedge aclk);
		#1;
		chk({store_valid, done}, 2'b00);
		@(posedge aclk);
		ce <= 1'b1;
		@(posedge aclk);
		instr_valid <= 1'b0;
		#1;
		chk({store_valid, done}, 2'b11);
		chk(store_addr, 64'h40);
	endtask

	// each mask bit alone; -1 vs 1 and 5 vs -5 split signed from unsigned
	task automatic traps();
		logic [4:0] to;
		for (int i = 0; i < 5; i++) begin
			to = 5'h01 << i;
			issue(xf(to, 5'h03, `XO_TRAP_RR, 1'b0), '1, 64'h1, src_val, 1'b0,
				{4'h0, |(to & 5'h11), 4'h1});
			issue({`OPC_TDI, to, 5'h03, 16'hfffb}, 64'h5, 0, src_val, 1'b0,
				{4'h0, |(to & 5'h0a), 4'h1});
		end
		issue(xf(5'h04, 5'h03, `XO_TRAP_RR, 1'b0), 64'h7, 64'h7, src_val, 1'b0, 9'h011);
	endtask

	// flushes refused, privilege, and sync waits for prompt and slow partner
	task automatic flushes();
		int n;
		supervisor <= 1'b1;
		issue(xf(5'h00, 5'h00, `XO_TLBIA, 1'b0), 0, 0, 0, 1'b0, 9'h009);
		issue(xf(5'h00, 5'h00, `XO_TLBIEX, 1'b0), 0, 64'h3, 0, 1'b0, 9'h009);
		supervisor <= 1'b0;
		op = xf(5'h00, 5'h00, `XO_TLBSYNC, 1'b0);
		issue(op, 0, 0, 0, 1'b0, 9'h003);
		supervisor <= 1'b1;
		for (int s = 0; s < 2; s++) begin
			slow <= s[0];
			issue(op, 0, 0, 0, 1'b0, 9'h000);
			chk({sync_req, instr_ready}, 2'b10);
			n = 0;
			while (!done && n < 100) begin
				@(posedge aclk);
				#1;
				n++;
			end
			if (n >= 100) hang();
			chk(n > (s ? 20 : 1), 1'b1);
			chk({sync_req, instr_ready}, 2'b01);
		end
	endtask

	// main sequence
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{instr_valid, reservation, supervisor, slow, summary_overflow_flag} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{instr, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		{base_gpr, index_gpr, source_gpr, source_fpr} = '0;
		s_axi_wstrb = 4'hf;
		ce = 1'b1;
		failures = 0;
		checks_done = 0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		regs_check();
		narrow_mode();
		cond_store();
		update_stores();
		indexed_stores();
		freeze();
		traps();
		flushes();
		axi_read(`REG_STORES);
		chk(rd, 32'h6);
		axi_read(`REG_ILLEGAL);
		chk(rd, 32'ha);
		axi_read(`REG_TRAPS);
		chk(rd, 32'h5);
		give_verdict();
	end
endmodule
`default_nettype wire
